// ===== bench/sfb_mem_model.sv
// Memory partner model: answers every request with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module sfb_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Memory port
  input wire sfb_pkg::sfb_mem_req_t mem_req,
  output var sfb_pkg::sfb_mem_rsp_t mem_rsp
);
  logic [1:0] wait_cnt;
  // Fixed three-cycle latency, well inside one bit time so no byte is lost
  always_ff @(posedge ref_clk) begin
    if (rst || !mem_req.valid || mem_rsp.done) begin
      wait_cnt <= 2'h0;
      mem_rsp.done <= 1'b0;
      mem_rsp.fail <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      mem_rsp.done <= (wait_cnt == 2'h2);
    end
    mem_rsp.rdata <= mem_req.addr[7:0] ^ 8'hA5;
  end
endmodule : sfb_mem_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the serial boot command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rxd = 1'b1;
  logic txd;
  logic busy;
  logic run_ram;
  logic blank = 1'b0;
  int busy_cycles = 0;
  int ram_writes = 0;
  logic [7:0] ram_sum = 8'h00;
  sfb_pkg::sfb_mem_req_t mem_req;
  sfb_pkg::sfb_mem_rsp_t mem_rsp;
  int failures = 0;
  int comparisons = 0;
  int runs = 0;
  int bitp = 1041;
  int n;
  logic [7:0] got [$];
  logic [7:0] tx [$];
  logic [7:0] d0;
  logic [7:0] d1;
  ////////////////////////////////////////////////////////////////////////////
  sfb_boot_cmd sfb_boot_cmd_i (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .serial_receive_in(rxd),
    .serial_transmit_out(txd), .busy_handshake_out(busy), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .flash_blank(blank), .run_ram(run_ram));
  sfb_mem_model sfb_mem_model_i (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_rsp(mem_rsp));
  initial forever #50 ref_clk = ~ref_clk;
  // One-cycle events are caught here so the main sequence cannot miss them
  always @(posedge ref_clk) begin
    if (run_ram === 1'b1) runs <= runs + 1;
    if (busy === 1'b1) busy_cycles <= busy_cycles + 1;
    // RAM writes counted at their done pulse, while the request still stands
    if (mem_rsp.done === 1'b1 && mem_req.op == sfb_pkg::OP_WR_RAM) begin
      ram_writes <= ram_writes + 1;
      ram_sum <= ram_sum + mem_req.wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Expected download checksum: byte sum modulo 256
  function automatic logic [7:0] checksum(input logic [7:0] a, input logic [7:0] b);
    return 8'(a + b);
  endfunction : checksum
  // Host side 8N1 frame, LSB first
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (bitp) @(posedge ref_clk);
    end
  endtask : send_byte
  // Mid-bit sampling of one reply frame, bounded wait for its start bit
  task automatic recv_byte();
    logic [7:0] b;
    int k;
    k = 0;
    while (txd !== 1'b0 && k < 60 * bitp) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (bitp / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitp) @(posedge ref_clk);
      b[i] = txd;
    end
    repeat (bitp) @(posedge ref_clk);
    check("stop bit", {7'h0, txd}, 8'h01);
    got.push_back(b);
  endtask : recv_byte
  // Replies overlap the tail of the request, so both run in parallel
  task automatic xfer(input int nr);
    got.delete();
    fork
      foreach (tx[i]) send_byte(tx[i]);
      for (int k = 0; k < nr; k++) recv_byte();
    join
    tx.delete();
  endtask : xfer
  task automatic final_report();
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized a little above the expected run length of about 100k cycles
  initial begin
    repeat (105000) @(posedge ref_clk);
    failures++;
    final_report();
  end
  // Main sequence
  initial begin
    d0 = 8'($urandom(52561));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tx = '{8'hB3};
    xfer(1);
    check("rate echo", got[0], 8'hB3);
    // Let the rest of the echo stop bit pass before the rate moves
    repeat (600) @(posedge ref_clk);
    bitp = 173;
    // Lock query before the id check is dropped, status still answers
    tx = '{8'h71, 8'h0F, 8'hFF, 8'h70};
    xfer(2);
    check("primary status", got[0], 8'h80);
    check("secondary status", got[1], 8'h00);
    // Blank flash opens the protected clear, busy pulses for one cycle
    blank <= 1'b1;
    tx = '{8'h50};
    xfer(0);
    blank <= 1'b0;
    check("clear busy pulse", 8'(busy_cycles), 8'h01);
    tx = '{8'hF5, 8'hDF, 8'hFF, 8'h0F, 8'h07};
    for (int i = 0; i < 7; i++) tx.push_back(sfb_pkg::ID_ADDR[i][7:0] ^ 8'hA5);
    xfer(0);
    tx = '{8'h71, 8'h0F, 8'hFF};
    xfer(1);
    check("lock reply", got[0], 8'hFF);
    tx = '{8'hFB};
    xfer(8);
    for (int i = 0; i < 8; i++) check("version", got[i], sfb_pkg::VERSION_STR[63 - 8 * i -: 8]);
    // Random payload, first with a wrong checksum, then with the right one
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    tx = '{8'hFA, 8'h02, 8'h00, 8'(checksum(d0, d1) + 8'h01), d0, d1};
    xfer(0);
    repeat (40) @(posedge ref_clk);
    check("run on bad sum", 8'(runs), 8'h00);
    tx = '{8'hFA, 8'h02, 8'h00, checksum(d0, d1), d0, d1};
    xfer(0);
    repeat (40) @(posedge ref_clk);
    check("run on good sum", 8'(runs), 8'h01);
    check("ram writes", 8'(ram_writes), 8'h04);
    check("ram data sum", ram_sum, 8'(2 * checksum(d0, d1)));
    check("busy before erase", 8'(busy_cycles), 8'h01);
    tx = '{8'hA7, 8'hD0};
    xfer(0);
    n = 0;
    // Host holds off while busy is high
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check("erase busy seen", {7'h0, busy_cycles > 1}, 8'h01);
    check("erase busy end", {7'h0, busy}, 8'h00);
    final_report();
  end
endmodule : tb
`default_nettype wire

// ===== design/sfb_boot_cmd.sv
// Serial boot command interpreter with its own serial receiver and transmitter
`timescale 1ns/1ps
`default_nettype none
module sfb_boot_cmd #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Serial link
  input wire logic serial_receive_in,
  output logic serial_transmit_out,
  output logic busy_handshake_out,
  // Flash, boot ROM and RAM port
  output sfb_pkg::sfb_mem_req_t mem_req,
  input wire sfb_pkg::sfb_mem_rsp_t mem_rsp,
  input wire logic flash_blank,
  // Hand control to the loaded program
  output logic run_ram
);
  sfb_pkg::sfb_state_t state;
  sfb_pkg::sfb_state_t ret;
  logic [7:0] cmd;
  logic [31:0] args;
  logic [31:0] next_args;
  logic [15:0] cnt;
  logic [15:0] page;
  logic [15:0] dl_size;
  logic [7:0] dl_ck;
  logic [7:0] dl_sum;
  logic [7:0] id_count;
  logic [7:0] id_rx;
  logic [7:0] rd_byte;
  logic have_byte;
  logic mismatch;
  logic id_ok;
  logic err_high;
  logic err_low;
  logic cksum_err;
  logic [1:0] baud_sel;
  logic [10:0] div;
  logic [2:0] nargs;
  logic [7:0] send_byte;
  logic [15:0] send_len;
  logic is_prot;
  logic locked;
  // Receiver
  logic rx_busy;
  logic [10:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_strobe;
  logic [7:0] rx_byte;
  // Transmitter and its FIFO
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic tx_busy;
  logic [10:0] tx_cnt;
  logic [3:0] tx_bits;
  logic [8:0] tx_shift;

  ////////////////////////////////////////////////////////////////////////////
  // Bit period for the selected rate
  always_comb begin
    if (baud_sel == 2'h1) begin
      div = sfb_pkg::DIV_19200;
    end else if (baud_sel == 2'h2) begin
      div = sfb_pkg::DIV_38400;
    end else if (baud_sel == 2'h3) begin
      div = sfb_pkg::DIV_57600;
    end else begin
      div = sfb_pkg::DIV_9600;
    end
  end

  // Receiver: samples mid-bit, drops false starts and bad stop bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_busy <= 1'b0;
      rx_cnt <= 11'h000;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_strobe <= 1'b0;
      rx_byte <= 8'h00;
    end else if (ce) begin
      rx_strobe <= 1'b0;
      if (!rx_busy) begin
        if (!serial_receive_in) begin
          rx_busy <= 1'b1;
          rx_cnt <= {1'b0, div[10:1]};
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt == 11'h000) begin
        rx_cnt <= div - 11'h001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          rx_busy <= !serial_receive_in;
        end else if (rx_bit <= 4'h8) begin
          rx_shift <= {serial_receive_in, rx_shift[7:1]};
        end else begin
          rx_busy <= 1'b0;
          rx_strobe <= serial_receive_in;
          rx_byte <= rx_shift;
        end
      end else begin
        rx_cnt <= rx_cnt - 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO: sequencer stalls while tx_valid waits for room
  sfb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_out_valid),
    .out_ready(!tx_busy),
    .out_data(fifo_out_data)
  );

  // Transmitter: start bit, eight data bits LSB first, one stop bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_cnt <= 11'h000;
      tx_bits <= 4'h0;
      tx_shift <= 9'h1FF;
      serial_transmit_out <= 1'b1;
    end else if (ce) begin
      if (!tx_busy) begin
        if (fifo_out_valid) begin
          tx_busy <= 1'b1;
          tx_shift <= {1'b1, fifo_out_data};
          tx_bits <= 4'h9;
          tx_cnt <= div - 11'h001;
          serial_transmit_out <= 1'b0;
        end
      end else if (tx_cnt == 11'h000) begin
        tx_cnt <= div - 11'h001;
        if (tx_bits == 4'h0) begin
          tx_busy <= 1'b0;
        end else begin
          serial_transmit_out <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[8:1]};
          tx_bits <= tx_bits - 4'h1;
        end
      end else begin
        tx_cnt <= tx_cnt - 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Argument counts, reply bytes and the protection check
  assign next_args = {args[23:0], rx_byte};
  assign locked = !id_ok && !flash_blank;
  always_comb begin
    is_prot = (rx_byte == sfb_pkg::CMD_PAGE_READ) || (rx_byte == sfb_pkg::CMD_PAGE_PROG) ||
              (rx_byte == sfb_pkg::CMD_ERASE_ALL) || (rx_byte == sfb_pkg::CMD_CLEAR) ||
              (rx_byte == sfb_pkg::CMD_LOCK) || (rx_byte == sfb_pkg::CMD_DOWNLOAD) ||
              (rx_byte == sfb_pkg::CMD_BOOT_DUMP);
    if (cmd == sfb_pkg::CMD_ERASE_ALL) begin
      nargs = 3'h1;
    end else if (cmd == sfb_pkg::CMD_DOWNLOAD) begin
      nargs = 3'h3;
    end else if (cmd == sfb_pkg::CMD_ID_CHECK) begin
      nargs = 3'h4;
    end else begin
      nargs = 3'h2;
    end
    send_byte = 8'h00;
    send_len = 16'h0001;
    if (cmd == sfb_pkg::CMD_STATUS) begin
      send_len = sfb_pkg::STATUS_LEN;
      if (cnt == 16'h0000) begin
        send_byte[sfb_pkg::ST_READY_BIT] = !busy_handshake_out;
        send_byte[sfb_pkg::ERR_HIGH_BIT] = err_high;
        send_byte[sfb_pkg::ERR_LOW_BIT] = err_low;
      end else begin
        send_byte[sfb_pkg::ST2_ID_OK_BIT] = id_ok;
        send_byte[sfb_pkg::ST2_CKSUM_BIT] = cksum_err;
      end
    end else if (cmd == sfb_pkg::CMD_LOCK) begin
      send_byte = sfb_pkg::LOCK_REPLY;
    end else if (cmd == sfb_pkg::CMD_VERSION) begin
      send_len = sfb_pkg::VERSION_LEN;
      send_byte = sfb_pkg::VERSION_STR[{3'(3'h7 - cnt[2:0]), 3'h0} +: 8];
    end else begin
      send_byte = cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer; bytes arriving during a memory wait are lost
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= sfb_pkg::S_IDLE;
      ret <= sfb_pkg::S_IDLE;
      cmd <= 8'h00;
      args <= 32'h0000_0000;
      cnt <= 16'h0000;
      page <= 16'h0000;
      dl_size <= 16'h0000;
      dl_ck <= 8'h00;
      dl_sum <= 8'h00;
      id_count <= 8'h00;
      id_rx <= 8'h00;
      rd_byte <= 8'h00;
      have_byte <= 1'b0;
      mismatch <= 1'b0;
      id_ok <= 1'b0;
      err_high <= 1'b0;
      err_low <= 1'b0;
      cksum_err <= 1'b0;
      baud_sel <= sfb_pkg::BAUD_SEL_RESET;
      busy_handshake_out <= 1'b0;
      mem_req <= '0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      run_ram <= 1'b0;
    end else if (ce) begin
      run_ram <= 1'b0;
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      case (state)
        sfb_pkg::S_IDLE: begin
          if (rx_strobe) begin
            cmd <= rx_byte;
            cnt <= 16'h0000;
            mismatch <= 1'b0;
            if (is_prot && locked) begin
              state <= sfb_pkg::S_IDLE;
            end else if (rx_byte == sfb_pkg::CMD_STATUS || rx_byte == sfb_pkg::CMD_VERSION ||
                         rx_byte[7:2] == sfb_pkg::CMD_BAUD_BASE) begin
              state <= sfb_pkg::S_SEND;
            end else if (rx_byte == sfb_pkg::CMD_CLEAR) begin
              err_high <= 1'b0;
              err_low <= 1'b0;
              busy_handshake_out <= 1'b1;
              state <= sfb_pkg::S_CLR;
            end else if (rx_byte == sfb_pkg::CMD_PAGE_READ || rx_byte == sfb_pkg::CMD_PAGE_PROG ||
                         rx_byte == sfb_pkg::CMD_ERASE_ALL || rx_byte == sfb_pkg::CMD_LOCK ||
                         rx_byte == sfb_pkg::CMD_ID_CHECK || rx_byte == sfb_pkg::CMD_DOWNLOAD ||
                         rx_byte == sfb_pkg::CMD_BOOT_DUMP) begin
              state <= sfb_pkg::S_ARG;
            end
          end
        end
        sfb_pkg::S_ARG: begin
          if (rx_strobe) begin
            args <= next_args;
            cnt <= cnt + 16'h0001;
            if (cnt[2:0] == nargs - 3'h1) begin
              cnt <= 16'h0000;
              page <= {next_args[7:0], next_args[15:8]};
              dl_size <= {next_args[15:8], next_args[23:16]};
              dl_ck <= next_args[7:0];
              dl_sum <= 8'h00;
              id_count <= next_args[7:0];
              if (cmd == sfb_pkg::CMD_ERASE_ALL) begin
                state <= sfb_pkg::S_IDLE;
                if (rx_byte == sfb_pkg::CMD_CONFIRM) begin
                  mem_req <= '{1'b1, sfb_pkg::OP_ERASE, 24'h000000, 8'h00};
                  busy_handshake_out <= 1'b1;
                  state <= sfb_pkg::S_WAIT;
                  ret <= sfb_pkg::S_IDLE;
                end
              end else if (cmd == sfb_pkg::CMD_PAGE_PROG) begin
                state <= sfb_pkg::S_PROG;
              end else if (cmd == sfb_pkg::CMD_LOCK) begin
                state <= sfb_pkg::S_SEND;
              end else if (cmd == sfb_pkg::CMD_ID_CHECK) begin
                state <= sfb_pkg::S_ID;
              end else if (cmd == sfb_pkg::CMD_DOWNLOAD) begin
                state <= sfb_pkg::S_DL;
              end else begin
                have_byte <= 1'b0;
                state <= sfb_pkg::S_RD;
              end
            end
          end
        end
        sfb_pkg::S_PROG: begin
          if (cnt == sfb_pkg::PAGE_BYTES) begin
            mem_req <= '{1'b1, sfb_pkg::OP_PROGRAM, {page, 8'h00}, 8'h00};
            busy_handshake_out <= 1'b1;
            state <= sfb_pkg::S_WAIT;
            ret <= sfb_pkg::S_IDLE;
          end else if (rx_strobe) begin
            mem_req <= '{1'b1, sfb_pkg::OP_WR_BUF, {page, cnt[7:0]}, rx_byte};
            cnt <= cnt + 16'h0001;
            state <= sfb_pkg::S_WAIT;
            ret <= sfb_pkg::S_PROG;
          end
        end
        sfb_pkg::S_RD: begin
          if (have_byte) begin
            if (!tx_valid) begin
              tx_valid <= 1'b1;
              tx_data <= rd_byte;
              have_byte <= 1'b0;
              cnt <= cnt + 16'h0001;
              if (cnt == sfb_pkg::PAGE_BYTES - 16'h0001) begin
                state <= sfb_pkg::S_IDLE;
              end
            end
          end else begin
            mem_req.valid <= 1'b1;
            mem_req.op <= (cmd == sfb_pkg::CMD_BOOT_DUMP) ? sfb_pkg::OP_RD_BOOT : sfb_pkg::OP_RD_FLASH;
            mem_req.addr <= {page, cnt[7:0]};
            have_byte <= 1'b1;
            state <= sfb_pkg::S_WAIT;
            ret <= sfb_pkg::S_RD;
          end
        end
        sfb_pkg::S_WAIT: begin
          if (mem_rsp.done) begin
            mem_req.valid <= 1'b0;
            rd_byte <= mem_rsp.rdata;
            state <= ret;
            if (mem_req.op == sfb_pkg::OP_PROGRAM) begin
              busy_handshake_out <= 1'b0;
              err_high <= mem_rsp.fail;
            end else if (mem_req.op == sfb_pkg::OP_ERASE) begin
              busy_handshake_out <= 1'b0;
              err_low <= mem_rsp.fail;
            end
            if (ret == sfb_pkg::S_ID && mem_rsp.rdata != id_rx) begin
              mismatch <= 1'b1;
            end
          end
        end
        sfb_pkg::S_ID: begin
          if (cnt == {8'h00, id_count}) begin
            id_ok <= !mismatch && (cnt == sfb_pkg::ID_LEN);
            state <= sfb_pkg::S_IDLE;
          end else if (rx_strobe) begin
            cnt <= cnt + 16'h0001;
            if (cnt < sfb_pkg::ID_LEN) begin
              id_rx <= rx_byte;
              mem_req <= '{1'b1, sfb_pkg::OP_RD_FLASH, sfb_pkg::ID_ADDR[cnt[2:0]], 8'h00};
              state <= sfb_pkg::S_WAIT;
              ret <= sfb_pkg::S_ID;
            end
          end
        end
        sfb_pkg::S_DL: begin
          if (cnt == dl_size) begin
            cksum_err <= (dl_sum != dl_ck);
            run_ram <= (dl_sum == dl_ck);
            state <= sfb_pkg::S_IDLE;
          end else if (rx_strobe) begin
            dl_sum <= dl_sum + rx_byte;
            mem_req <= '{1'b1, sfb_pkg::OP_WR_RAM, {8'h00, cnt}, rx_byte};
            cnt <= cnt + 16'h0001;
            state <= sfb_pkg::S_WAIT;
            ret <= sfb_pkg::S_DL;
          end
        end
        sfb_pkg::S_SEND: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_data <= send_byte;
            cnt <= cnt + 16'h0001;
            if (cnt == send_len - 16'h0001) begin
              state <= (cmd[7:2] == sfb_pkg::CMD_BAUD_BASE) ? sfb_pkg::S_BAUD : sfb_pkg::S_IDLE;
            end
          end
        end
        sfb_pkg::S_BAUD: begin
          // Switch only after the echo has fully left the line
          if (!tx_valid && !fifo_out_valid && !tx_busy) begin
            baud_sel <= cmd[1:0];
            state <= sfb_pkg::S_IDLE;
          end
        end
        sfb_pkg::S_CLR: begin
          busy_handshake_out <= 1'b0;
          state <= sfb_pkg::S_IDLE;
        end
        default: begin
          state <= sfb_pkg::S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_busy_program: assert property (@(posedge ref_clk) disable iff (rst)
    (mem_req.valid && mem_req.op == sfb_pkg::OP_PROGRAM) |-> busy_handshake_out)
    else $error("busy low while page program runs");
  chk_erase_confirm: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(mem_req.valid) && mem_req.op == sfb_pkg::OP_ERASE |-> $past(rx_byte) == sfb_pkg::CMD_CONFIRM)
    else $error("erase started without confirm byte");
  chk_lock_reply: assert property (@(posedge ref_clk) disable iff (rst || !ce)
    (state == sfb_pkg::S_SEND && cmd == sfb_pkg::CMD_LOCK && !tx_valid) |=>
      (tx_valid && tx_data == sfb_pkg::LOCK_REPLY))
    else $error("lock reply not all ones");
  chk_run_match: assert property (@(posedge ref_clk) disable iff (rst)
    run_ram |-> (dl_sum == dl_ck && !cksum_err))
    else $error("loaded program started with bad checksum");
  chk_page_length: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(mem_req.valid) && mem_req.op == sfb_pkg::OP_PROGRAM |-> cnt == sfb_pkg::PAGE_BYTES)
    else $error("page programmed before 256 bytes");
  chk_protect_refuse: assert property (@(posedge ref_clk) disable iff (rst || !ce)
    (state == sfb_pkg::S_IDLE && rx_strobe && is_prot && locked) |=> state == sfb_pkg::S_IDLE)
    else $error("protected command accepted while locked");
  chk_baud_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (baud_sel != $past(baud_sel)) |-> $past(!fifo_out_valid && !tx_busy && state == sfb_pkg::S_BAUD))
    else $error("rate changed before echo finished");
  chk_clear_busy: assert property (@(posedge ref_clk) disable iff (rst || !ce)
    (state == sfb_pkg::S_IDLE && rx_strobe && rx_byte == sfb_pkg::CMD_CLEAR && !locked) |=>
      (busy_handshake_out && !err_high && !err_low) ##1 !busy_handshake_out)
    else $error("clear status did not pulse busy");
endmodule : sfb_boot_cmd
`default_nettype wire

// ===== design/sfb_fifo.sv
// Parameterised valid/ready FIFO for the transmit byte path
`timescale 1ns/1ps
`default_nettype none
module sfb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = store[rd_ptr[AW-1:0]];
  assign do_push = ce && in_valid && in_ready;
  assign do_pop = ce && out_valid && out_ready;

  // Storage write, no reset needed for data
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : sfb_fifo
`default_nettype wire

// ===== design/sfb_pkg.sv
// Constants and types for the serial boot command interpreter
package sfb_pkg;
  // Clock and serial rates
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_9600 = 9_600;
  localparam int unsigned BAUD_19200 = 19_200;
  localparam int unsigned BAUD_38400 = 38_400;
  localparam int unsigned BAUD_57600 = 57_600;
  localparam logic [10:0] DIV_9600 = 11'(CLK_HZ / BAUD_9600);
  localparam logic [10:0] DIV_19200 = 11'(CLK_HZ / BAUD_19200);
  localparam logic [10:0] DIV_38400 = 11'(CLK_HZ / BAUD_38400);
  localparam logic [10:0] DIV_57600 = 11'(CLK_HZ / BAUD_57600);
  localparam logic [1:0] BAUD_SEL_RESET = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_PAGE_READ = 8'hFF;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
  localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_LOCK = 8'h71;
  localparam logic [7:0] CMD_ID_CHECK = 8'hF5;
  localparam logic [7:0] CMD_DOWNLOAD = 8'hFA;
  localparam logic [7:0] CMD_VERSION = 8'hFB;
  localparam logic [7:0] CMD_BOOT_DUMP = 8'hFC;
  localparam logic [5:0] CMD_BAUD_BASE = 6'h2C;
  localparam logic [7:0] LOCK_REPLY = 8'hFF;
  ////////////////////////////////////////////////////////////////////////////
  // Lengths
  localparam logic [15:0] PAGE_BYTES = 16'h0100;
  localparam logic [15:0] VERSION_LEN = 16'h0008;
  localparam logic [15:0] STATUS_LEN = 16'h0002;
  localparam logic [15:0] ID_LEN = 16'h0007;
  // Arbitrary neutral version text "VER 1.00", first character in the top byte
  localparam logic [63:0] VERSION_STR = 64'h5645_5220_312E_3030;
  // Stored identification byte addresses, first byte first
  localparam logic [23:0] ID_ADDR [0:6] = '{24'h0FFFDF, 24'h0FFFE3, 24'h0FFFEB, 24'h0FFFEF,
                                           24'h0FFFF3, 24'h0FFFF7, 24'h0FFFFB};
  ////////////////////////////////////////////////////////////////////////////
  // Status byte fields
  localparam int unsigned ST_READY_BIT = 7;
  localparam int unsigned ERR_HIGH_BIT = 4;
  localparam int unsigned ERR_LOW_BIT = 3;
  localparam int unsigned ST2_ID_OK_BIT = 2;
  localparam int unsigned ST2_CKSUM_BIT = 1;
  ////////////////////////////////////////////////////////////////////////////
  // Memory port
  typedef enum logic [2:0] {
    OP_RD_FLASH = 3'b000,
    OP_RD_BOOT = 3'b001,
    OP_WR_BUF = 3'b010,
    OP_PROGRAM = 3'b011,
    OP_ERASE = 3'b100,
    OP_WR_RAM = 3'b101
  } sfb_op_t;
  typedef struct packed {
    logic valid;
    sfb_op_t op;
    logic [23:0] addr;
    logic [7:0] wdata;
  } sfb_mem_req_t;
  typedef struct packed {
    logic done;
    logic fail;
    logic [7:0] rdata;
  } sfb_mem_rsp_t;
  // Command sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ARG = 4'b0001,
    S_PROG = 4'b0010,
    S_RD = 4'b0011,
    S_WAIT = 4'b0100,
    S_ID = 4'b0101,
    S_DL = 4'b0110,
    S_SEND = 4'b0111,
    S_BAUD = 4'b1000,
    S_CLR = 4'b1001
  } sfb_state_t;
endpackage : sfb_pkg
